// ### fault_reaction_map.svh
`ifndef FAULT_REACTION_MAP_SVH
`define FAULT_REACTION_MAP_SVH
// register byte addresses
`define FRM_ADDR_STATUS 12'h000
`define FRM_ADDR_MASK 12'h004
`define FRM_ADDR_FSSEL 12'h008
`define FRM_ADDR_CLEAR 12'h00c
`define FRM_ADDR_OUT 12'h010
// status bit positions
`define FRM_B_CLKMON 0
`define FRM_B_REGP 1
`define FRM_B_REGS 2
`define FRM_B_COMMP 3
`define FRM_B_COMMS 4
`define FRM_B_SER 5
`define FRM_B_CFGP 6
`define FRM_B_CFGS 7
`define FRM_B_TRIMP 8
`define FRM_B_TRIMS 9
`define FRM_B_BISTP 10
`define FRM_B_BISTS 11
`define FRM_NFLAGS 12
// mask bit positions
`define FRM_M_CLKMON 0
`define FRM_M_REGP 1
`define FRM_M_REGS 2
`define FRM_M_COMMP 3
`define FRM_M_COMMS 4
`define FRM_M_SER 5
`define FRM_M_CFGP 6
`define FRM_M_CFGS 7
`define FRM_M_BISTP 8
`define FRM_M_BISTS 9
`define FRM_NMASK 10
// reset values: all masks enabled except the primary communication alarm
`define FRM_MASK_RST 10'h3f7
// fail-safe selector slots, 3 bits each
`define FRM_S_REGP 0
`define FRM_S_REGS 1
`define FRM_S_SER 2
`define FRM_S_CFGP 3
`define FRM_S_CFGS 4
`define FRM_S_TRIMS 5
`define FRM_S_COMMP 6
`define FRM_S_COMMS 7
`define FRM_NSEL 8
// default selection: serial slot no action, others pull low
`define FRM_FSSEL_RST 24'h249309
// clear key written to the clear register
`define FRM_CLEAR_KEY 32'h0000a5a5
`endif

// ### fault_reaction_pkg.sv
`default_nettype none
package fault_reaction_pkg;
    // driver output and serial port action codes
    typedef enum logic [2:0] {
        act_enabled = 3'h0,
        act_pull_low = 3'h1,
        act_disabled = 3'h2,
        act_high_z = 3'h3,
        act_no_action = 3'h4,
        act_soft_off = 3'h5
    } action_t;
endpackage : fault_reaction_pkg
`default_nettype wire

// ### fault_sel_if.sv
`default_nettype none
// carries the fail-safe selector word between the bus slave and the reaction core
interface fault_sel_if;
    logic [23:0] fssel;
    logic [9:0] mask;
    logic [11:0] flags;
    modport slave (output fssel, output mask, input flags);
    modport core (input fssel, input mask, output flags);
endinterface : fault_sel_if
`default_nettype wire

// ### fault_regs.sv
`default_nettype none
`include "fault_reaction_map.svh"
// ahb-lite slave: mask, fail-safe selectors, status read, clear key
module fault_regs (
    // bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // core side
    fault_sel_if.slave sel,
    input wire logic [2:0] out_state,
    input wire logic serial_en,
    output logic clear_pulse
);
    logic wr_pend_r;
    logic [11:0] wr_addr_r;
    logic [23:0] fssel_r;
    logic [9:0] mask_r;
    logic take;
    assign take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign sel.fssel = fssel_r;
    assign sel.mask = mask_r;
    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else if (hready) begin
            wr_pend_r <= take && hwrite;
            wr_addr_r <= haddr;
        end
    end
    // write data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fssel_r <= `FRM_FSSEL_RST;
            mask_r <= `FRM_MASK_RST;
        end else if (wr_pend_r) begin
            if (wr_addr_r == `FRM_ADDR_MASK) mask_r <= hwdata[9:0];
            if (wr_addr_r == `FRM_ADDR_FSSEL) fssel_r <= hwdata[23:0];
        end
    end
    assign clear_pulse = wr_pend_r && (wr_addr_r == `FRM_ADDR_CLEAR) && (hwdata == `FRM_CLEAR_KEY);
    // read data registered at address phase; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (take && !hwrite) begin
            case (haddr)
                `FRM_ADDR_STATUS: hrdata <= {20'h0, sel.flags};
                `FRM_ADDR_MASK: hrdata <= {22'h0, mask_r};
                `FRM_ADDR_FSSEL: hrdata <= {8'h0, fssel_r};
                `FRM_ADDR_OUT: hrdata <= {28'h0, serial_en, out_state};
                default: hrdata <= 32'h0;
            endcase
        end
    end
endmodule : fault_regs
`default_nettype wire

// ### fault_reaction_manager.sv
`default_nettype none
`include "fault_reaction_map.svh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - secondary clock monitor fault sets flag, pulls output low, port on, alarm masked.
// - regulator fault sets side flag, applies side fail-safe, port on, alarm.
// - primary logic regulator overvoltage acts as secondary comm fault, port off, alarm.
// - secondary logic regulator overvoltage acts as primary comm fault, port stays on.
// - serial faults share one flag, selectable output, no alarm, warning asserted.
// - config crc fault sets side flag, side fail-safe, port on, masked alarm.
// - primary trim crc always pulls low; secondary trim output selectable.
// - trim crc fault drives alarm and warning via that side's config-crc mask.
// - self-test fault sets side flag, pulls low, alarm and warning via mask.
// - action codes: enabled, pull low, disabled, high-z, no action, soft off.
module fault_reaction_manager
    import fault_reaction_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // fault detections, level or pulse
    input wire logic det_clkmon_sec,
    input wire logic det_reg_pri,
    input wire logic det_reg_sec,
    input wire logic det_primary_logic_regulator_ov,
    input wire logic det_secondary_logic_regulator_ov,
    input wire logic det_serial_clk,
    input wire logic det_serial_addr,
    input wire logic det_serial_crc,
    input wire logic det_cfg_crc_pri,
    input wire logic det_cfg_crc_sec,
    input wire logic det_trim_crc_pri,
    input wire logic det_trim_crc_sec,
    input wire logic det_bist_pri,
    input wire logic det_bist_sec,
    // reactions
    output fault_reaction_pkg::action_t driver_action,
    output fault_reaction_pkg::action_t serial_action,
    output logic alarm_pin_n,
    output logic warning_pin_n
);
    import fault_reaction_pkg::*;

    fault_sel_if sel_bus ();
    logic clear_pulse;
    logic [11:0] flags_r;
    logic [11:0] ev;
    logic serial_off_r;
    action_t drv_nxt;
    logic alarm_nxt;
    logic warn_nxt;

    ////////////////////////////////////////////////////////////////////////////
    fault_regs u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .sel(sel_bus.slave),
        .out_state(driver_action),
        .serial_en(serial_action == act_enabled),
        .clear_pulse(clear_pulse)
    );

    // event vector; logic regulator overvoltages fold into comm faults
    always_comb begin
        ev = '0;
        ev[`FRM_B_CLKMON] = det_clkmon_sec;
        ev[`FRM_B_REGP] = det_reg_pri;
        ev[`FRM_B_REGS] = det_reg_sec;
        ev[`FRM_B_COMMS] = det_primary_logic_regulator_ov;
        ev[`FRM_B_COMMP] = det_secondary_logic_regulator_ov;
        ev[`FRM_B_SER] = det_serial_clk | det_serial_addr | det_serial_crc;
        ev[`FRM_B_CFGP] = det_cfg_crc_pri;
        ev[`FRM_B_CFGS] = det_cfg_crc_sec;
        ev[`FRM_B_TRIMP] = det_trim_crc_pri;
        ev[`FRM_B_TRIMS] = det_trim_crc_sec;
        ev[`FRM_B_BISTP] = det_bist_pri;
        ev[`FRM_B_BISTS] = det_bist_sec;
    end

    // sticky flags, set wins over the recovery clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_r <= '0;
        end else begin
            flags_r <= (clear_pulse ? 12'h000 : flags_r) | ev;
        end
    end
    assign sel_bus.flags = flags_r;

    // serial port latch: primary logic regulator overvoltage disables the port
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_off_r <= 1'b0;
        end else if (det_primary_logic_regulator_ov) begin
            serial_off_r <= 1'b1;
        end else if (clear_pulse) begin
            serial_off_r <= 1'b0;
        end
    end
    assign serial_action = serial_off_r ? act_disabled : act_enabled;

    // highest-priority fail-safe choice: pull low beats selectable choices
    function automatic action_t pick(input action_t cur, input logic hit, input action_t a);
        begin
            if (!hit) pick = cur;
            else if (cur == act_pull_low || a == act_pull_low) pick = act_pull_low;
            else if (cur == act_enabled || cur == act_no_action) pick = a;
            else pick = cur;
        end
    endfunction : pick

    // driver output and pin terms from the latched flags
    always_comb begin
        logic [23:0] s;
        logic [9:0] m;
        logic [11:0] f;
        s = sel_bus.fssel;
        m = sel_bus.mask;
        f = flags_r;
        drv_nxt = act_enabled;
        drv_nxt = pick(drv_nxt, f[`FRM_B_CLKMON], act_pull_low);
        drv_nxt = pick(drv_nxt, f[`FRM_B_REGP], action_t'(s[3*`FRM_S_REGP +: 3]));
        drv_nxt = pick(drv_nxt, f[`FRM_B_REGS], action_t'(s[3*`FRM_S_REGS +: 3]));
        drv_nxt = pick(drv_nxt, f[`FRM_B_COMMP], action_t'(s[3*`FRM_S_COMMP +: 3]));
        drv_nxt = pick(drv_nxt, f[`FRM_B_COMMS], action_t'(s[3*`FRM_S_COMMS +: 3]));
        drv_nxt = pick(drv_nxt, f[`FRM_B_SER], action_t'(s[3*`FRM_S_SER +: 3]));
        drv_nxt = pick(drv_nxt, f[`FRM_B_CFGP], action_t'(s[3*`FRM_S_CFGP +: 3]));
        drv_nxt = pick(drv_nxt, f[`FRM_B_CFGS], action_t'(s[3*`FRM_S_CFGS +: 3]));
        drv_nxt = pick(drv_nxt, f[`FRM_B_TRIMP], act_pull_low);
        drv_nxt = pick(drv_nxt, f[`FRM_B_TRIMS], action_t'(s[3*`FRM_S_TRIMS +: 3]));
        drv_nxt = pick(drv_nxt, f[`FRM_B_BISTP] | f[`FRM_B_BISTS], act_pull_low);
        alarm_nxt = (f[`FRM_B_CLKMON] & m[`FRM_M_CLKMON])
            | (f[`FRM_B_REGP] & m[`FRM_M_REGP]) | (f[`FRM_B_REGS] & m[`FRM_M_REGS])
            | (f[`FRM_B_COMMP] & m[`FRM_M_COMMP])
            | (f[`FRM_B_COMMS] & m[`FRM_M_COMMS])
            | ((f[`FRM_B_CFGP] | f[`FRM_B_TRIMP]) & m[`FRM_M_CFGP])
            | ((f[`FRM_B_CFGS] | f[`FRM_B_TRIMS]) & m[`FRM_M_CFGS])
            | (f[`FRM_B_BISTP] & m[`FRM_M_BISTP]) | (f[`FRM_B_BISTS] & m[`FRM_M_BISTS]);
        warn_nxt = (f[`FRM_B_SER] & m[`FRM_M_SER])
            | (f[`FRM_B_TRIMP] & m[`FRM_M_CFGP]) | (f[`FRM_B_TRIMS] & m[`FRM_M_CFGS])
            | (f[`FRM_B_BISTP] & m[`FRM_M_BISTP]) | (f[`FRM_B_BISTS] & m[`FRM_M_BISTS]);
    end

    // registered reaction outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            driver_action <= act_enabled;
            alarm_pin_n <= 1'b1;
            warning_pin_n <= 1'b1;
        end else begin
            driver_action <= drv_nxt;
            alarm_pin_n <= ~alarm_nxt;
            warning_pin_n <= ~warn_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_clkmon_hit;
        det_clkmon_sec && sel_bus.mask[`FRM_M_CLKMON] && !clear_pulse;
    endsequence
    sequence s_pulled_low_alarm;
        (driver_action == act_pull_low) && !alarm_pin_n;
    endsequence
    sequence s_both_pins_low;
        !alarm_pin_n && !warning_pin_n;
    endsequence
    a_clkmon_reaction: assert property (@(posedge hclk) disable iff (!hresetn)
        s_clkmon_hit |-> ##2 s_pulled_low_alarm)
        else $error("clock monitor reaction missing");
    a_clkmon_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
        det_clkmon_sec |=> flags_r[`FRM_B_CLKMON])
        else $error("clock monitor flag not set");
    a_reg_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
        det_reg_pri && !serial_off_r && !det_primary_logic_regulator_ov
        |=> flags_r[`FRM_B_REGP] && serial_action == act_enabled)
        else $error("regulator flag not set");
    a_prilogic_port_off: assert property (@(posedge hclk) disable iff (!hresetn)
        det_primary_logic_regulator_ov
        |=> serial_action == act_disabled && flags_r[`FRM_B_COMMS])
        else $error("serial port not disabled");
    a_port_stays_off: assert property (@(posedge hclk) disable iff (!hresetn)
        serial_off_r && !clear_pulse |=> serial_action == act_disabled)
        else $error("serial port enabled without clear");
    a_seclogic_port_on: assert property (@(posedge hclk) disable iff (!hresetn)
        det_secondary_logic_regulator_ov && !serial_off_r && !det_primary_logic_regulator_ov
        |=> flags_r[`FRM_B_COMMP] && serial_action == act_enabled)
        else $error("secondary regulator overvoltage reaction wrong");
    a_serial_warn: assert property (@(posedge hclk) disable iff (!hresetn)
        det_serial_crc && sel_bus.mask[`FRM_M_SER] && !clear_pulse |-> ##2 !warning_pin_n)
        else $error("serial warning missing");
    a_serial_flag_shared: assert property (@(posedge hclk) disable iff (!hresetn)
        det_serial_clk |=> flags_r[`FRM_B_SER])
        else $error("serial clock fault flag not set");
    a_cfg_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
        det_cfg_crc_sec |=> flags_r[`FRM_B_CFGS])
        else $error("config crc flag not set");
    a_trim_pull_low: assert property (@(posedge hclk) disable iff (!hresetn)
        det_trim_crc_pri && !clear_pulse |-> ##2 driver_action == act_pull_low)
        else $error("primary trim fault not pulled low");
    a_trim_pins: assert property (@(posedge hclk) disable iff (!hresetn)
        det_trim_crc_sec && sel_bus.mask[`FRM_M_CFGS] && !clear_pulse
        |-> ##2 s_both_pins_low)
        else $error("trim fault pins wrong");
    a_trim_pri_pins: assert property (@(posedge hclk) disable iff (!hresetn)
        det_trim_crc_pri && sel_bus.mask[`FRM_M_CFGP] && !clear_pulse
        |-> ##2 s_both_pins_low)
        else $error("primary trim fault pins wrong");
    a_bist_reaction: assert property (@(posedge hclk) disable iff (!hresetn)
        det_bist_sec && !clear_pulse |-> ##2 driver_action == act_pull_low)
        else $error("self-test fault not pulled low");
    a_flags_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        !clear_pulse && flags_r[`FRM_B_SER] |=> flags_r[`FRM_B_SER])
        else $error("flag dropped without clear");
endmodule : fault_reaction_manager
`default_nettype wire

// ### host_model.sv
`default_nettype none
`include "fault_reaction_map.svh"
// bus master standing in for the host controller
module host_model (
    // clock and bus answer
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // bus request
    output logic hsel,
    output logic [11:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // set when the slave never answers
    output logic hang
);
    timeunit 1ns;
    timeprecision 1ps;
    // bus idle at time zero, word transfers only
    initial begin
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        hang = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // waits for hready under a bound so a dead slave cannot stall the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1) hang <= 1'b1;
    endtask : wait_ready
    // single word: address phase held until ready, then data phase held until ready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : ~d; // read phases carry the inverse of d
        wait_ready();
        q = hrdata;
    endtask : xfer
    // recovery after supply cycling: clear, then rewrite the whole configuration
    task automatic recover(input logic [31:0] m, input logic [31:0] s);
        logic [31:0] q;
        xfer(1'b1, `FRM_ADDR_CLEAR, `FRM_CLEAR_KEY, q);
        xfer(1'b1, `FRM_ADDR_MASK, m, q);
        xfer(1'b1, `FRM_ADDR_FSSEL, s, q);
    endtask : recover
endmodule : host_model
`default_nettype wire

// ### testbench.sv
`default_nettype none
`include "fault_reaction_map.svh"
// self-checking bench for the fault reaction manager
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fault_reaction_pkg::*;
    typedef struct {
        logic [11:0] flag;
        action_t drv;
        action_t ser;
        logic [1:0] pins;
    } row_t;
    localparam action_t low = act_pull_low;
    localparam action_t en = act_enabled;
    localparam action_t ds = act_disabled;
    localparam action_t na = act_no_action;
    localparam action_t hz = act_high_z;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, alarm_pin_n, warning_pin_n, hang;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, q;
    logic [13:0] det;
    action_t driver_action, serial_action;
    int n_errors = 0;
    int checked = 0;
    // one row per detection input: flags, output, port, {alarm, warning}
    row_t rows [14] = '{
        '{12'h001, low, en, 2'b01}, '{12'h002, low, en, 2'b01}, '{12'h004, low, en, 2'b01},
        '{12'h010, low, ds, 2'b01}, '{12'h008, low, en, 2'b11}, '{12'h020, na, en, 2'b10},
        '{12'h020, na, en, 2'b10}, '{12'h020, na, en, 2'b10}, '{12'h040, low, en, 2'b01},
        '{12'h080, low, en, 2'b01}, '{12'h100, low, en, 2'b00}, '{12'h200, low, en, 2'b00},
        '{12'h400, low, en, 2'b00}, '{12'h800, low, en, 2'b00}};
    ////////////////////////////////////////////////////////////////////////////
    fault_reaction_manager DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .det_clkmon_sec(det[0]), .det_reg_pri(det[1]), .det_reg_sec(det[2]),
        .det_primary_logic_regulator_ov(det[3]), .det_secondary_logic_regulator_ov(det[4]),
        .det_serial_clk(det[5]), .det_serial_addr(det[6]), .det_serial_crc(det[7]),
        .det_cfg_crc_pri(det[8]), .det_cfg_crc_sec(det[9]), .det_trim_crc_pri(det[10]),
        .det_trim_crc_sec(det[11]), .det_bist_pri(det[12]), .det_bist_sec(det[13]),
        .driver_action(driver_action), .serial_action(serial_action),
        .alarm_pin_n(alarm_pin_n), .warning_pin_n(warning_pin_n));
    host_model host (
        .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hang(hang));
    // 250 mhz clock
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_w
    task automatic cmp_a(input action_t got, input action_t exp);
        cmp_w({29'h0, got}, {29'h0, exp});
    endtask : cmp_a
    // one-cycle detection pulse, then let the reaction land
    task automatic fire(input int i);
        @(posedge hclk);
        det <= 14'h1 << i;
        @(posedge hclk);
        det <= 14'h0;
        repeat (3) @(posedge hclk);
        #1;
    endtask : fire
    // reactions, then status over the bus, then pins again to see them held
    task automatic expect_row(input row_t r);
        cmp_a(driver_action, r.drv);
        cmp_a(serial_action, r.ser);
        cmp_w({30'h0, alarm_pin_n, warning_pin_n}, {30'h0, r.pins});
        host.xfer(1'b0, `FRM_ADDR_STATUS, 32'h0, q);
        cmp_w(q, {20'h0, r.flag});
        cmp_w({30'h0, alarm_pin_n, warning_pin_n}, {30'h0, r.pins});
        host.xfer(1'b0, `FRM_ADDR_OUT, 32'h0, q);
        cmp_w(q, {28'h0, r.ser == en, r.drv});
    endtask : expect_row
    task automatic expect_idle();
        cmp_a(driver_action, en);
        cmp_a(serial_action, en);
        cmp_w({30'h0, alarm_pin_n, warning_pin_n}, 32'h3);
        cmp_w({30'h0, hreadyout, hresp}, 32'h2);
    endtask : expect_idle
    ////////////////////////////////////////////////////////////////////////////
    // bounded run: a stuck bus or a long hang ends in the report
    initial begin
        for (int c = 0; c < 20000 && hang !== 1'b1; c++) @(posedge hclk);
        n_errors++;
        stop_test();
    end
    initial begin
        hresetn = 1'b0;
        det = 14'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        // mask reset value and an unmapped read
        host.xfer(1'b0, `FRM_ADDR_MASK, 32'h0, q);
        cmp_w(q, {22'h0, `FRM_MASK_RST});
        host.xfer(1'b0, `FRM_ADDR_FSSEL, 32'h0, q);
        cmp_w(q, {8'h0, `FRM_FSSEL_RST});
        host.xfer(1'b0, 12'h100, 32'h0, q);
        cmp_w(q, 32'h0);
        expect_idle();
        // every detection with the default configuration
        for (int i = 0; i < 14; i++) begin
            fire(i);
            expect_row(rows[i]);
            host.recover({22'h0, `FRM_MASK_RST}, {8'h0, `FRM_FSSEL_RST});
            expect_idle();
        end
        // clock monitor alarm masked: output still pulled low, pin stays high
        host.recover({22'h0, `FRM_MASK_RST & 10'h3fe}, {8'h0, `FRM_FSSEL_RST});
        fire(0);
        expect_row('{12'h001, low, en, 2'b11});
        // all selectors high impedance, config-crc alarms masked on both sides
        host.recover(32'h337, 32'h006db6db);
        fire(10);
        expect_row('{12'h100, low, en, 2'b11});
        host.recover(32'h337, 32'h006db6db);
        fire(11);
        expect_row('{12'h200, hz, en, 2'b11});
        host.recover(32'h337, 32'h006db6db);
        fire(2);
        expect_row('{12'h004, hz, en, 2'b01});
        host.recover(32'h337, 32'h006db6db);
        fire(6);
        expect_row('{12'h020, hz, en, 2'b10});
        host.recover(32'h337, 32'h006db6db);
        fire(9);
        expect_row('{12'h080, hz, en, 2'b11});
        // a wrong clear key and a status write leave everything latched
        host.recover({22'h0, `FRM_MASK_RST}, {8'h0, `FRM_FSSEL_RST});
        fire(1);
        host.xfer(1'b1, `FRM_ADDR_CLEAR, 32'h0000a5a4, q);
        host.xfer(1'b1, `FRM_ADDR_STATUS, 32'h0, q);
        expect_row('{12'h002, low, en, 2'b01});
        // reset in mid-run drops flags and reactions
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
        expect_idle();
        @(posedge hclk);
        hresetn <= 1'b1;
        host.xfer(1'b0, `FRM_ADDR_STATUS, 32'h0, q);
        cmp_w(q, 32'h0);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
